// *** include/bwp_pkg.sv ***
// package: bus cycle timing constants and command carrier
`default_nettype none
package bwp_pkg;
  // ************************************************************
  // widths and timing
  // ************************************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CLK_PERIOD_NS = 50;
  // zero-wait cycle is two clocks, one wait state adds one clock
  localparam int ZERO_WAIT_CLKS = 2;
  localparam int WAIT_STATE_CLKS = 1;
  // ************************************************************
  // reset values of bus pins
  // ************************************************************
  localparam logic RST_STROBE_N = 1'h1;
  localparam logic [ADDR_W-1:0] RST_ADDR = 32'hffffffff;
  localparam logic [DATA_W-1:0] RST_DATA = 32'h00000000;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    BWP_IDLE,
    BWP_T1,
    BWP_T2
  } bwp_state_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic mem_io;
    logic [DATA_W-1:0] wdata;
  } bwp_cmd_t;
  localparam bwp_cmd_t RST_CMD = '{addr: RST_ADDR, write: 1'h0,
                                   mem_io: 1'h0, wdata: RST_DATA};
endpackage : bwp_pkg
`default_nettype wire

// *** logic/bwp_bus_ctrl.sv ***
// processor-side bus cycle sequencer with wait states and pipelining
`default_nettype none
module bwp_bus_ctrl (
  input wire logic CLOCK, // processor clock
  input wire logic RST_N, // synchronous reset, active low
  input wire logic REQ_VALID, // core offers a bus request
  input wire bwp_pkg::bwp_cmd_t REQ_CMD, // request address, kind, data
  output logic REQ_READY, // request slot free
  output logic DONE, // one-clock pulse per finished cycle
  output logic [bwp_pkg::DATA_W-1:0] RD_DATA, // read data of done cycle
  output logic [bwp_pkg::ADDR_W-1:0] ADDR, // address pins
  output logic WRITE, // write/read status pin
  output logic MEM_IO, // memory/io status pin
  output logic ADDRESS_STROBE_N, // address strobe, active low
  input wire logic READY_N, // cycle acknowledge, active low
  input wire logic NEXT_ADDRESS_REQUEST_N, // pipeline request, active low
  input wire logic [bwp_pkg::DATA_W-1:0] DATA_IN, // data pins in
  output logic [bwp_pkg::DATA_W-1:0] DATA_OUT, // data pins out
  output logic DATA_OE, // data pin drive enable
  output logic BUS_BUSY // a bus cycle is in progress
);
  // ************************************************************
  // state
  // ************************************************************
  bwp_pkg::bwp_state_t state_r;
  bwp_pkg::bwp_state_t state_nxt;
  bwp_pkg::bwp_cmd_t pend_r;
  logic pend_v_r;
  logic pend_v_nxt;
  bwp_pkg::bwp_cmd_t cur_r;
  bwp_pkg::bwp_cmd_t cur_nxt;
  bwp_pkg::bwp_cmd_t next_r;
  logic pipe_r;
  logic accept;
  logic in_t2;
  logic complete;
  logic issue_pipe;
  logic issue_fresh;
  logic issue;

  // ************************************************************
  // cycle decode
  // ************************************************************
  assign accept = REQ_READY && REQ_VALID;
  assign in_t2 = (state_r == bwp_pkg::BWP_T2);
  // cycle ends on acknowledge in T2; else one more wait clock
  assign complete = in_t2 && !READY_N;
  // early issue only with a request already held and no pipe yet
  assign issue_pipe = in_t2 && READY_N && !NEXT_ADDRESS_REQUEST_N
                      && !pipe_r && pend_v_r;
  // from idle the address goes out in its own T1
  assign issue_fresh = pend_v_r && ((state_r == bwp_pkg::BWP_IDLE)
                       || (complete && !pipe_r));
  assign issue = issue_pipe || issue_fresh;
  assign pend_v_nxt = (pend_v_r && !issue) || accept;

  always_comb
  begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    unique case (state_r)
      bwp_pkg::BWP_IDLE:
      begin
        if (issue_fresh)
        begin
          state_nxt = bwp_pkg::BWP_T1;
          cur_nxt = pend_r;
        end
      end
      bwp_pkg::BWP_T1:
      begin
        state_nxt = bwp_pkg::BWP_T2;
      end
      bwp_pkg::BWP_T2:
      begin
        if (complete)
        begin
          if (pipe_r)
          begin
            // pipelined cycle skips T1, address already out
            state_nxt = bwp_pkg::BWP_T2;
            cur_nxt = next_r;
          end
          else if (issue_fresh)
          begin
            // not pipelined: plain T1 timing
            state_nxt = bwp_pkg::BWP_T1;
            cur_nxt = pend_r;
          end
          else
          begin
            state_nxt = bwp_pkg::BWP_IDLE;
          end
        end
      end
    endcase
  end

  // ************************************************************
  // sequencer registers
  // ************************************************************
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      state_r <= bwp_pkg::BWP_IDLE;
      cur_r <= bwp_pkg::RST_CMD;
    end
    else
    begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
    end
  end

  // pipelined address held until its cycle takes over
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      pipe_r <= 1'h0;
      next_r <= bwp_pkg::RST_CMD;
    end
    else if (issue_pipe)
    begin
      pipe_r <= 1'h1;
      next_r <= pend_r;
    end
    else if (complete)
    begin
      pipe_r <= 1'h0;
    end
  end

  // ************************************************************
  // request slot
  // ************************************************************
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      pend_v_r <= 1'h0;
      pend_r <= bwp_pkg::RST_CMD;
      REQ_READY <= 1'h0;
    end
    else
    begin
      pend_v_r <= pend_v_nxt;
      REQ_READY <= !pend_v_nxt;
      if (accept)
      begin
        pend_r <= REQ_CMD;
      end
    end
  end

  // ************************************************************
  // address and status pins
  // ************************************************************
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      ADDRESS_STROBE_N <= bwp_pkg::RST_STROBE_N;
      ADDR <= bwp_pkg::RST_ADDR;
      WRITE <= 1'h0;
      MEM_IO <= 1'h0;
    end
    else
    begin
      ADDRESS_STROBE_N <= !issue;
      if (issue)
      begin
        ADDR <= pend_r.addr;
        WRITE <= pend_r.write;
        MEM_IO <= pend_r.mem_io;
      end
    end
  end

  // ************************************************************
  // data pins and completion
  // ************************************************************
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      DATA_OUT <= bwp_pkg::RST_DATA;
      DATA_OE <= 1'h0;
      DONE <= 1'h0;
      RD_DATA <= bwp_pkg::RST_DATA;
      BUS_BUSY <= 1'h0;
    end
    else
    begin
      DATA_OUT <= cur_nxt.wdata;
      DATA_OE <= cur_nxt.write && (state_nxt != bwp_pkg::BWP_IDLE);
      DONE <= complete;
      BUS_BUSY <= (state_nxt != bwp_pkg::BWP_IDLE);
      if (complete && !cur_r.write)
      begin
        RD_DATA <= DATA_IN;
      end
    end
  end
endmodule : bwp_bus_ctrl
`default_nettype wire

// *** dv/bwp_bus_ctrl_chk.sv ***
// checker: timing properties of the bus sequencer
`default_nettype none
module bwp_bus_ctrl_chk (
  input wire logic CLOCK, // clock
  input wire logic RST_N, // reset
  input wire logic REQ_READY, // slot free
  input wire logic DONE, // cycle done
  input wire logic ADDRESS_STROBE_N, // strobe
  input wire logic READY_N, // acknowledge
  input wire logic NEXT_ADDRESS_REQUEST_N, // pipeline request
  input wire logic BUS_BUSY // busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  // first cycle after an idle bus
  sequence s_post_idle;
    !BUS_BUSY ##1 !ADDRESS_STROBE_N;
  endsequence
  a_wait_done: assert property (
    s_post_idle ##1 READY_N ##1 !READY_N |=> DONE)
    else $error("cycle did not end after one wait");
  a_wait_hold: assert property (
    s_post_idle ##1 READY_N |=> !DONE)
    else $error("cycle ended during a wait");
  a_next_addr: assert property (
    s_post_idle ##1 (READY_N && !REQ_READY && !NEXT_ADDRESS_REQUEST_N)
    |=> !ADDRESS_STROBE_N)
    else $error("next address not driven");
  a_no_early: assert property (
    s_post_idle ##1 (READY_N && NEXT_ADDRESS_REQUEST_N) |=> ADDRESS_STROBE_N)
    else $error("cycle pipelined without request");
endmodule : bwp_bus_ctrl_chk
bind bwp_bus_ctrl bwp_bus_ctrl_chk u_chk (.CLOCK(CLOCK), .RST_N(RST_N),
  .REQ_READY(REQ_READY), .DONE(DONE), .ADDRESS_STROBE_N(ADDRESS_STROBE_N),
  .READY_N(READY_N), .NEXT_ADDRESS_REQUEST_N(NEXT_ADDRESS_REQUEST_N),
  .BUS_BUSY(BUS_BUSY));
`default_nettype wire

// *** dv/bwp_partner.sv ***
// partner: wait-state and pipelining control logic, read data from latched address
`default_nettype none
module bwp_partner (
  input wire logic CLOCK, // clock
  input wire logic RST_N, // reset
  input wire logic NA_EN, // pipelining enabled
  input wire logic ADDRESS_STROBE_N, // strobe
  input wire logic MEM_IO, // memory when high
  input wire logic [31:0] ADDR, // address
  output logic READY_N, // acknowledge
  output logic NEXT_ADDRESS_REQUEST_N, // pipeline request
  output logic [31:0] DATA_IN // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic act_r, pend_r, ack, stb;
  logic [2:0] cnt_r, pcnt_r, w;
  logic [31:0] a_r;
  assign stb = !ADDRESS_STROBE_N;
  assign ack = act_r && cnt_r == 3'h0;
  assign w = MEM_IO ? 3'h1 : 3'h4;
  assign READY_N = !ack;
  assign NEXT_ADDRESS_REQUEST_N = !(NA_EN && act_r
                                   && !pend_r);
  assign DATA_IN = act_r ? ~a_r : a_r;
  always_ff @(posedge CLOCK)
  begin
    if (stb)
      a_r <= ADDR;
    if (!RST_N)
      act_r <= 1'h0;
    else if (stb && !act_r)
      act_r <= 1'h1;
    else if (ack && !pend_r && !stb)
      act_r <= 1'h0;
    if (!RST_N)
      pend_r <= 1'h0;
    else if (stb && act_r && !ack)
      pend_r <= 1'h1;
    else if (ack)
      pend_r <= 1'h0;
    if (stb)
      pcnt_r <= w - 3'h1;
    if (stb && !act_r)
      cnt_r <= w;
    else if (stb && ack)
      cnt_r <= w - 3'h1;
    else if (ack && pend_r)
      cnt_r <= pcnt_r;
    else if (act_r && !ack)
      cnt_r <= cnt_r - 3'h1;
  end
endmodule : bwp_partner
`default_nettype wire

// *** dv/test_bwp_bus_ctrl.sv ***
// testbench: bus cycle timing with and without pipelining
`default_nettype none
module test_bwp_bus_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_n, valid, na_en, rdy, done, stb_n, rdy_n, na_n, busy;
  logic wr, mio, oe;
  logic [31:0] addr, rdata, din, dout;
  bwp_pkg::bwp_cmd_t cmd;
  int cyc, err_total, total_checks;
  int sq[$], dq[$];
  logic [31:0] wq[$];
  bwp_bus_ctrl uut (.CLOCK(clock), .RST_N(rst_n), .REQ_VALID(valid),
    .REQ_CMD(cmd), .REQ_READY(rdy), .DONE(done), .RD_DATA(rdata),
    .ADDR(addr), .WRITE(wr), .MEM_IO(mio), .ADDRESS_STROBE_N(stb_n),
    .READY_N(rdy_n), .NEXT_ADDRESS_REQUEST_N(na_n), .DATA_IN(din),
    .DATA_OUT(dout), .DATA_OE(oe), .BUS_BUSY(busy));
  bwp_partner u_far (.CLOCK(clock), .RST_N(rst_n), .NA_EN(na_en),
    .ADDRESS_STROBE_N(stb_n), .MEM_IO(mio), .ADDR(addr), .READY_N(rdy_n),
    .NEXT_ADDRESS_REQUEST_N(na_n), .DATA_IN(din));
  // ****************************************
  // clock, monitor, tasks
  // ****************************************
  initial
  begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (rst_n && !stb_n) sq.push_back(cyc);
    if (rst_n && done) dq.push_back(cyc);
    if (rst_n && oe && !rdy_n) wq.push_back(dout);
  end
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk
  task send(input logic [31:0] a, input logic w, input logic m);
    @(negedge clock);
    valid = 1'h1;
    cmd = '{addr: a, write: w, mem_io: m, wdata: ~a};
    for (int n = 0; n < 50 && rdy !== 1'h1; n++) @(negedge clock);
    @(posedge clock);
  endtask : send
  task wait_done(input int n);
    @(negedge clock);
    valid = 1'h0;
    for (int k = 0; k < 100 && dq.size() < n; k++) @(negedge clock);
    repeat (3) @(negedge clock);
  endtask : wait_done
  task pair(input logic na, input logic m1);
    sq.delete();
    dq.delete();
    wq.delete();
    na_en = na;
    send(32'h00001000, 1'b0, 1'b0);
    send(32'h00002000, 1'b1, m1);
    wait_done(2);
  endtask : pair
  task t_single;
    for (int m = 0; m < 2; m++)
    begin
      sq.delete();
      dq.delete();
      send(32'h00000100 + m, 1'b0, m[0]);
      wait_done(1);
      chk("cycle length", m ? 3 : 6, dq[0] - sq[0]);
      chk("read data", ~(32'h00000100 + m), rdata);
    end
    $display("single cycles done");
  endtask : t_single
  task t_pipe;
    pair(1'b1, 1'b1);
    chk("early strobe", 1, sq[1] < dq[0]);
    chk("first length", 6, dq[0] - sq[0]);
    chk("memory gap", 1, dq[1] - dq[0]);
    chk("write data", ~32'h00002000, wq[0]);
    pair(1'b1, 1'b0);
    chk("io gap", 4, dq[1] - dq[0]);
    $display("pipelined cycles done");
  endtask : t_pipe
  task t_nopipe;
    pair(1'b0, 1'b1);
    chk("plain length", 3, dq[1] - sq[1]);
    chk("late strobe", 1, sq[1] >= dq[0]);
    chk("write data", ~32'h00002000, wq[0]);
    $display("plain cycles done");
  endtask : t_nopipe
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (2000) @(posedge clock);
    err_total++;
    finish_test;
  end
  initial
  begin
    rst_n = 1'h0;
    valid = 1'h0;
    na_en = 1'h0;
    cmd = bwp_pkg::RST_CMD;
    repeat (20) @(negedge clock);
    rst_n = 1'h1;
    repeat (2) @(negedge clock);
    t_single;
    t_pipe;
    t_nopipe;
    finish_test;
  end
endmodule : test_bwp_bus_ctrl
`default_nettype wire
